// ### include/rpsl_pkg.sv
package rpsl_pkg;
  // ------------------------------------------------------------
  // Data memory map
  // ------------------------------------------------------------
  localparam logic [11:0] RPSL_PIN0_OUT_ADDR = 12'hec1;
  localparam logic [11:0] RPSL_PIN2_OUT_ADDR = 12'hec3;
  localparam logic [11:0] RPSL_PIN1_OUT_ADDR = 12'hec7;
  // Input selector and control register addresses (not printed)
  localparam logic [11:0] RPSL_UART2_RX_SEL_ADDR = 12'hee4;
  localparam logic [11:0] RPSL_CTRL_ADDR = 12'heff;
  localparam logic [11:0] RPSL_KEY_ADDR = 12'hfa7;
  // Bank that holds the remap registers
  localparam logic [3:0] RPSL_REMAP_BANK = 4'he;
  // ------------------------------------------------------------
  // Field layout and values
  // ------------------------------------------------------------
  localparam int RPSL_FUNC_W = 5;
  localparam int RPSL_PIN_W = 5;
  localparam int RPSL_LOCK_BIT = 0;
  localparam logic [7:0] RPSL_KEY_FIRST = 8'h55;
  localparam logic [7:0] RPSL_KEY_SECOND = 8'haa;
  localparam logic [4:0] RPSL_FUNC_UART2_TX = 5'h06;
  localparam logic [4:0] RPSL_RESET_CODE = 5'h00;
  localparam logic [4:0] RPSL_RX_PIN_RESET = 5'h1f;
  // Key sequencer states, one-hot
  typedef enum logic [2:0] {
    RPSL_KEY_IDLE = 3'b001,
    RPSL_KEY_HALF = 3'b010,
    RPSL_KEY_OPEN = 3'b100
  } rpsl_key_type;
endpackage

// ### logic/rpsl_sel_mem.sv
`timescale 1ns/1ps
// Small register bank of function codes with a registered read port
module rpsl_sel_mem (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic we,
  input wire logic [1:0] waddr,
  input wire logic [4:0] wdata,
  input wire logic [1:0] raddr,
  output logic [4:0] rdata,
  output logic [4:0] code0,
  output logic [4:0] code1,
  output logic [4:0] code2
);
  import rpsl_pkg::*;
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [2:0][4:0] mem_reg;
    logic [4:0] rd_reg;
  } rpsl_mem_type;
  rpsl_mem_type s_reg;
  rpsl_mem_type s_next;
  // Next state: write port and registered read
  always_comb begin
    s_next = s_reg;
    if (we && waddr != 2'd3) begin
      s_next.mem_reg[waddr] = wdata;
    end
    s_next.rd_reg = (raddr == 2'd3) ? 5'h00 : s_reg.mem_reg[raddr];
  end
  // Registers
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  assign rdata = s_reg.rd_reg;
  assign code0 = s_reg.mem_reg[0];
  assign code1 = s_reg.mem_reg[1];
  assign code2 = s_reg.mem_reg[2];
endmodule

// ### logic/rpsl_top.sv
`timescale 1ns/1ps
// Operation
// R1: Remap registers writable only while unlocked
// R2: Lock bit clears on any reset
// R3: One-way config keeps lock set until reset
// R4: Software unlocks with 0x55 then 0xAA keys
// R5: Low five bits hold output function code
// R6: Upper three bits read as zero
// R7: Input selector holds pin; 0 routes pin0
// R8: Code 0x06 on pin1 drives UART2 TX
// R9: Registers live in bank 14, banked access
// R10: Remapping never enables the peripheral
// R11: Remapping never overrides analog pin setting
// R12: Key writes must be on consecutive writes
module rpsl_top (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic [11:0] ADDR,
  input wire logic WR_EN,
  input wire logic RD_EN,
  input wire logic [7:0] WDATA,
  output logic [7:0] RDATA,
  input wire logic ONE_WAY_LOCK_CONFIG,
  input wire logic [2:0] PIN_IN,
  input wire logic [2:0] PIN_ANALOG,
  input wire logic UART2_TX,
  output logic [2:0] PIN_OUT,
  output logic [2:0] PIN_OUT_VALID,
  output logic UART2_RX,
  output logic REMAP_LOCK_BIT,
  output logic [4:0] PIN0_FUNCTION_CODE,
  output logic [4:0] PIN1_FUNCTION_CODE,
  output logic [4:0] PIN2_FUNCTION_CODE
);
  import rpsl_pkg::*;
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Maps an output select address to its storage slot, 3 if none
  function automatic logic [1:0] slot_of(input logic [11:0] a);
    unique case (a)
      RPSL_PIN0_OUT_ADDR: slot_of = 2'd0;
      RPSL_PIN1_OUT_ADDR: slot_of = 2'd1;
      RPSL_PIN2_OUT_ADDR: slot_of = 2'd2;
      default: slot_of = 2'd3;
    endcase
  endfunction
  // True when the address sits in the remap bank
  function automatic logic in_bank(input logic [11:0] a);
    in_bank = (a[11:8] == RPSL_REMAP_BANK);
  endfunction
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    rpsl_key_type key;      // Key sequencer
    logic lock;             // Write protect for remap registers
    logic [4:0] rx_pin;     // Pin feeding the UART2 receiver
    logic [7:0] rdata;      // Registered read data
    logic [1:0] rsel;       // Source of read data
  } rpsl_state_type;
  rpsl_state_type s_reg;
  rpsl_state_type s_next;
  logic [1:0] wslot;
  logic mem_we;
  logic [4:0] mem_rdata;
  logic [4:0] code [3];
  logic remap_wr;
  assign wslot = slot_of(ADDR);
  // Remap writes pass only while unlocked, in bank 14
  assign remap_wr = WR_EN && !s_reg.lock && in_bank(ADDR); // R1 R9
  assign mem_we = remap_wr && wslot != 2'd3; // R1
  // ------------------------------------------------------------
  // Function code storage
  // ------------------------------------------------------------
  rpsl_sel_mem u_mem (
    .CLK(CLK),
    .ARST_N(ARST_N),
    .we(mem_we),
    .waddr(wslot),
    .wdata(WDATA[4:0]), // R5
    .raddr(wslot),
    .rdata(mem_rdata),
    .code0(code[0]),
    .code1(code[1]),
    .code2(code[2])
  );
  // Next state: key sequence, lock, input selector, reads
  always_comb begin
    s_next = s_reg;
    s_next.rsel = 2'd0;
    s_next.rdata = 8'h00;
    // Key sequence, any other write aborts it
    if (WR_EN) begin
      unique case (s_reg.key)
        RPSL_KEY_IDLE: begin
          if (ADDR == RPSL_KEY_ADDR && WDATA == RPSL_KEY_FIRST) begin
            s_next.key = RPSL_KEY_HALF; // R4
          end
        end
        RPSL_KEY_HALF: begin
          if (ADDR == RPSL_KEY_ADDR && WDATA == RPSL_KEY_SECOND) begin
            s_next.key = RPSL_KEY_OPEN; // R4 R12
          end else begin
            s_next.key = RPSL_KEY_IDLE; // R12
          end
        end
        RPSL_KEY_OPEN: begin
          s_next.key = RPSL_KEY_IDLE;
          if (ADDR == RPSL_CTRL_ADDR) begin
            // Set always allowed; clear blocked by one-way mode
            if (WDATA[RPSL_LOCK_BIT]) begin
              s_next.lock = 1'b1;
            end else if (!ONE_WAY_LOCK_CONFIG) begin
              s_next.lock = 1'b0; // R3
            end
          end
        end
        default: s_next.key = RPSL_KEY_IDLE;
      endcase
    end
    // Input selector
    if (remap_wr && ADDR == RPSL_UART2_RX_SEL_ADDR) begin
      s_next.rx_pin = WDATA[4:0]; // R7
    end
    // Read source
    if (RD_EN) begin
      if (ADDR == RPSL_CTRL_ADDR) begin
        s_next.rdata = {7'h00, s_reg.lock};
      end else if (ADDR == RPSL_UART2_RX_SEL_ADDR) begin
        s_next.rdata = {3'h0, s_reg.rx_pin};
      end else if (wslot != 2'd3) begin
        s_next.rsel = 2'd1;
      end
    end
  end
  // Registers; lock clears on reset
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s_reg.key <= RPSL_KEY_IDLE;
      s_reg.lock <= 1'b0; // R2
      s_reg.rx_pin <= RPSL_RX_PIN_RESET;
      s_reg.rdata <= 8'h00;
      s_reg.rsel <= 2'd0;
    end else begin
      s_reg <= s_next;
    end
  end
  // Read data, unimplemented bits zero
  always_comb begin
    RDATA = s_reg.rdata;
    if (s_reg.rsel == 2'd1) begin
      RDATA = {3'h0, mem_rdata}; // R6
    end
  end
  // ------------------------------------------------------------
  // Pin routing
  // ------------------------------------------------------------
  // Only routing; peripheral enables and analog setup stay elsewhere
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      PIN_OUT[i] = (code[i] == RPSL_FUNC_UART2_TX) && UART2_TX; // R8 R10
      PIN_OUT_VALID[i] = (code[i] != RPSL_RESET_CODE); // R10
    end
  end
  // Analog pins read low and are not turned digital
  always_comb begin
    UART2_RX = 1'b1;
    if (s_reg.rx_pin < 5'd3) begin
      UART2_RX = PIN_IN[s_reg.rx_pin[1:0]] &&
                 !PIN_ANALOG[s_reg.rx_pin[1:0]]; // R7 R11
    end
  end
  assign REMAP_LOCK_BIT = s_reg.lock;
  assign PIN0_FUNCTION_CODE = code[0];
  assign PIN1_FUNCTION_CODE = code[1];
  assign PIN2_FUNCTION_CODE = code[2];
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  // First key write, taken only from the idle state
  sequence key_first;
    s_reg.key == RPSL_KEY_IDLE && WR_EN && ADDR == RPSL_KEY_ADDR &&
      WDATA == RPSL_KEY_FIRST;
  endsequence
  // Second key write
  sequence key_second;
    WR_EN && ADDR == RPSL_KEY_ADDR && WDATA == RPSL_KEY_SECOND;
  endsequence
  // Key pair with one quiet cycle between the strobes
  sequence key_pair;
    key_first ##1 !WR_EN ##1 key_second;
  endsequence
  a_locked_no_write: assert property (@(posedge CLK) // R1
    disable iff (!ARST_N)
    s_reg.lock |=> $stable(code[1]))
    else $error("locked code changed");
  a_one_way_hold: assert property (@(posedge CLK) // R3
    disable iff (!ARST_N)
    ONE_WAY_LOCK_CONFIG && s_reg.lock |=> s_reg.lock)
    else $error("one way lock cleared");
  a_key_opens: assert property (@(posedge CLK) // R4
    disable iff (!ARST_N)
    key_pair |=> s_reg.key == RPSL_KEY_OPEN)
    else $error("key pair did not open");
  a_lock_set: assert property (@(posedge CLK) // R4
    disable iff (!ARST_N)
    s_reg.key == RPSL_KEY_OPEN && WR_EN && ADDR == RPSL_CTRL_ADDR &&
    WDATA[RPSL_LOCK_BIT] |=> s_reg.lock)
    else $error("lock not set after key");
  a_key_abort: assert property (@(posedge CLK) // R12
    disable iff (!ARST_N)
    s_reg.key == RPSL_KEY_HALF && WR_EN && ADDR != RPSL_KEY_ADDR
    |=> s_reg.key == RPSL_KEY_IDLE)
    else $error("abort missed");
  a_no_key_no_lock: assert property (@(posedge CLK) // R4
    disable iff (!ARST_N)
    s_reg.key != RPSL_KEY_OPEN |=> $stable(s_reg.lock))
    else $error("lock moved without key");
  a_code_write: assert property (@(posedge CLK) // R5
    disable iff (!ARST_N)
    mem_we && wslot == 2'd1 |=> code[1] == $past(WDATA[4:0]))
    else $error("code write lost");
  a_upper_zero: assert property (@(posedge CLK) // R6
    disable iff (!ARST_N)
    RDATA[7:5] == 3'h0)
    else $error("upper bits not zero");
  a_tx_route: assert property (@(posedge CLK) // R8
    disable iff (!ARST_N)
    code[1] == RPSL_FUNC_UART2_TX |-> PIN_OUT[1] == UART2_TX)
    else $error("tx not routed");
  a_rx_route: assert property (@(posedge CLK) // R7
    disable iff (!ARST_N)
    s_reg.rx_pin == 5'd0 && !PIN_ANALOG[0] |-> UART2_RX == PIN_IN[0])
    else $error("rx not routed");
  a_bank_only: assert property (@(posedge CLK) // R9
    disable iff (!ARST_N)
    WR_EN && !in_bank(ADDR) |=> $stable(s_reg.rx_pin))
    else $error("write outside bank");
endmodule

// ### tb/rpsl_pin_model.sv
`timescale 1ns/1ps
// Pin and peripheral side of the remap block
module rpsl_pin_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [2:0] analog_cfg,
  output logic [2:0] pin_in,
  output logic [2:0] pin_analog,
  output logic uart_tx
);
  // ----------------------------------------------
  // Pin activity
  // ----------------------------------------------
  logic [7:0] lfsr_reg; // Pattern source for pins and transmit line
  // Lines wander every cycle so a stale route shows up
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lfsr_reg <= 8'h5a;
    end else begin
      lfsr_reg <= {lfsr_reg[6:0],
        lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
    end
  end
  // Transmit output of the second UART
  assign uart_tx = lfsr_reg[7];
  // Remappable pin levels
  assign pin_in = lfsr_reg[2:0];
  // Analog mode per pin, set by the bench
  assign pin_analog = analog_cfg;
endmodule

// ### tb/rpsl_top_tb.sv
`timescale 1ns/1ps
// Self-checking bench for the remap select block
module rpsl_top_tb;
  import rpsl_pkg::*;
  // ----------------------------------------------
  // Signals
  // ----------------------------------------------
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [11:0] addr = 12'h000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic one_way = 1'b0;
  logic [2:0] analog_cfg = 3'h0;
  logic [7:0] rdata;
  logic [2:0] pin_in, pin_analog, pin_out, pin_out_valid;
  logic uart_tx, uart_rx, lock;
  logic [4:0] code0, code1, code2;
  logic [4:0] shadow [3]; // Expected code per pin
  logic exp_lock = 1'b0; // Expected lock state
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;
  // Clock of 50 ns period
  initial begin
    forever #25 clk = ~clk;
  end
  rpsl_top rpsl_top_i (.CLK(clk), .ARST_N(arst_n), .ADDR(addr),
    .WR_EN(wr_en), .RD_EN(rd_en), .WDATA(wdata), .RDATA(rdata),
    .ONE_WAY_LOCK_CONFIG(one_way), .PIN_IN(pin_in),
    .PIN_ANALOG(pin_analog), .UART2_TX(uart_tx), .PIN_OUT(pin_out),
    .PIN_OUT_VALID(pin_out_valid), .UART2_RX(uart_rx),
    .REMAP_LOCK_BIT(lock), .PIN0_FUNCTION_CODE(code0),
    .PIN1_FUNCTION_CODE(code1), .PIN2_FUNCTION_CODE(code2));
  rpsl_pin_model rpsl_pin_model_i (.clk(clk), .arst_n(arst_n),
    .analog_cfg(analog_cfg), .pin_in(pin_in), .pin_analog(pin_analog),
    .uart_tx(uart_tx));
  // ----------------------------------------------
  // Tasks and functions
  // ----------------------------------------------
  // Verdict and end of run
  task automatic report_and_stop();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Compare one byte and count
  task automatic check(input logic [7:0] seen, input logic [7:0] expd);
    comparisons++;
    if (seen !== expd) begin
      error_cnt++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, expd);
    end
  endtask
  // One write strobe, then an idle cycle
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    @(posedge clk);
    #2 wr_en = 1'b0;
    @(posedge clk);
    #2;
  endtask
  // One read strobe; data lands in the following cycle
  task automatic rd(input logic [11:0] a, input logic [7:0] expd);
    addr = a;
    rd_en = 1'b1;
    @(posedge clk);
    #2 rd_en = 1'b0;
    check(rdata, expd);
    @(posedge clk);
    #2;
  endtask
  // Address of a pin output selector
  function automatic logic [11:0] pin_addr(input int p);
    return (p == 0) ? RPSL_PIN0_OUT_ADDR :
      (p == 1) ? RPSL_PIN1_OUT_ADDR : RPSL_PIN2_OUT_ADDR;
  endfunction
  // Pin write; the expectation moves only while unlocked
  task automatic wr_pin(input int p, input logic [7:0] d);
    wr(pin_addr(p), d);
    if (!exp_lock) shadow[p] = d[4:0];
  endtask
  // Read back every selector and its code port
  task automatic check_pins();
    for (int p = 0; p < 3; p++) rd(pin_addr(p), {3'h0, shadow[p]});
    check({3'h0, code0}, {3'h0, shadow[0]});
    check({3'h0, code1}, {3'h0, shadow[1]});
    check({3'h0, code2}, {3'h0, shadow[2]});
  endtask
  // Key pair followed by the lock write
  task automatic set_lock(input logic v);
    wr(RPSL_KEY_ADDR, RPSL_KEY_FIRST);
    wr(RPSL_KEY_ADDR, RPSL_KEY_SECOND);
    wr(RPSL_CTRL_ADDR, {7'h00, v});
  endtask
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  // ----------------------------------------------
  // Main sequence
  // ----------------------------------------------
  initial begin
    void'($urandom(56732));
    shadow = '{default: 5'h00};
    repeat (8) @(posedge clk);
    #2 arst_n = 1'b1;
    @(posedge clk);
    #2;
    check({7'h00, lock}, 8'h00);
    check_pins();
    wr_pin(0, 8'hff);
    wr_pin(1, {3'h0, RPSL_FUNC_UART2_TX});
    check_pins();
    check({5'h0, pin_out}, {6'h0, uart_tx, 1'b0});
    check({5'h0, pin_out_valid}, 8'h03);
    wr(RPSL_UART2_RX_SEL_ADDR, 8'h00);
    // Pin 0 alternates between digital and analog while its level wanders
    for (int i = 0; i < 8; i++) begin
      analog_cfg = {2'h0, i[0]};
      @(posedge clk);
      #2 check({7'h0, uart_rx}, {7'h0, pin_in[0] & ~i[0]});
    end
    analog_cfg = 3'h0;
    rd(RPSL_UART2_RX_SEL_ADDR, 8'h00);
    // Same offset in another bank must not land
    wr(12'h1c7, 8'h0a);
    check_pins();
    for (int i = 0; i < 12; i++) wr_pin($urandom % 3, 8'($urandom));
    check_pins();
    set_lock(1'b1);
    exp_lock = 1'b1;
    check({7'h0, lock}, 8'h01);
    rd(RPSL_CTRL_ADDR, 8'h01);
    wr_pin(1, 8'h02);
    check_pins();
    // Key pair split by another write
    wr(RPSL_KEY_ADDR, RPSL_KEY_FIRST);
    wr(RPSL_PIN2_OUT_ADDR, 8'h01);
    wr(RPSL_KEY_ADDR, RPSL_KEY_SECOND);
    wr(RPSL_CTRL_ADDR, 8'h00);
    check({7'h0, lock}, 8'h01);
    set_lock(1'b0);
    exp_lock = 1'b0;
    check({7'h0, lock}, 8'h00);
    wr_pin(2, 8'h15);
    check_pins();
    // One-way lock holds against a valid clear
    one_way = 1'b1;
    set_lock(1'b1);
    exp_lock = 1'b1;
    set_lock(1'b0);
    check({7'h0, lock}, 8'h01);
    wr_pin(0, 8'h07);
    check_pins();
    // Reset in mid-run
    arst_n = 1'b0;
    shadow = '{default: 5'h00};
    exp_lock = 1'b0;
    repeat (2) @(posedge clk);
    #2 arst_n = 1'b1;
    @(posedge clk);
    #2;
    check({7'h0, lock}, 8'h00);
    check({7'h0, uart_rx}, 8'h01);
    check_pins();
    rd(12'h123, 8'h00);
    report_and_stop();
  end
endmodule
